// ---- common/psfm_pkg.sv ----
// Constants and carrier types for the power switch fault monitor
package psfm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_NS        = 20;
  localparam int OC_OFF_NS     = 100;
  localparam int OC_OFF_CYC    = (OC_OFF_NS / CLK_NS < 1) ? 1
                                 : OC_OFF_NS / CLK_NS;
  localparam int OC_WINDOW_NS  = 40;
  localparam int OC_WINDOW_CYC = (OC_WINDOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_PULSE_NS  = 30;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWM_HZ        = 9_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int SC_RESET_NS   = 250_000;
  localparam int SC_RESET_CYC  = (SC_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEW_FILT_CYC = 1024;

  // ----------------------------------------------------------------
  // Slew settings, 0 is the slowest rate, 15 the fastest
  // ----------------------------------------------------------------
  localparam logic [3:0] SLEW_GND   = 4'hf;
  localparam logic [3:0] SLEW_AUX   = 4'ha;
  localparam logic [3:0] SLEW_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic gate_cmd;
    logic oc_trip;
    logic sc_trip;
    logic gan_rise;
    logic gan_fall;
    logic drv_rise;
    logic drv_fall;
    logic supply_ok;
    logic series_on;
    logic slew_gnd;
    logic slew_aux;
    logic slew_open;
    logic drain_neg;
    logic drain_fwd;
    logic flag_in;
  } psfm_sense_t;

  typedef struct packed {
    logic gate_on;
    logic slow_off;
    logic aux_en;
    logic neg_en;
  } psfm_drive_t;

  typedef enum logic [2:0] {
    ST_START = 3'h0,
    ST_RUN   = 3'h1,
    ST_IDM   = 3'h3,
    ST_DRVOT = 3'h2,
    ST_SHORT = 3'h6,
    ST_SUPPLY_UNDERVOLTAGE_LOCK  = 3'h7
  } psfm_state_t;

endpackage

// ---- tb/psfm_ctrl_model.sv ----
// Behavioural converter controller: drives gate command, decodes status
module psfm_ctrl_model (
  // Clock
  input  wire logic       clock,
  // Requests from the bench
  input  wire logic       want_on,
  input  wire logic       combined,
  // Status pins
  input  wire logic       alarm_out_n,
  input  wire logic       overcurrent_flag_n,
  // Gate command and decoded status
  output logic            gate_cmd,
  output logic [1:0]      code
);
  timeunit 1ns;
  timeprecision 100ps;

  initial gate_cmd = 1'b0;

  // Command changes just after the edge; a long low request clears a latch
  always @(posedge clock) gate_cmd <= #1 want_on;

  // Flag pin carries no meaning once it was tied low at power-up
  assign code = {alarm_out_n, combined | overcurrent_flag_n};
endmodule // psfm_ctrl_model

// ---- tb/tb.sv ----
// Self-checking bench for the power switch fault monitor
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import psfm_pkg::*;

  logic        clock;
  logic        sys_rst;
  psfm_sense_t sn;
  psfm_sense_t sense_w;
  logic [3:0]  slew_res_code;
  logic [7:0]  temp_duty;
  psfm_drive_t drv;
  logic [3:0]  slew_setting;
  logic        alarm_out_n;
  logic        overcurrent_flag_n;
  logic        flag_oe_n;
  logic        pwm;
  logic        want_on;
  logic        tie_flag;
  logic        gate_cmd;
  logic [1:0]  code;
  logic        flag_pin;
  int          fail_count;
  int          total_checks;

  // Flag pin: driven when enabled, else board tie or pull-up
  assign flag_pin = !flag_oe_n ? overcurrent_flag_n : !tie_flag;
  always_comb begin
    sense_w = sn;
    sense_w.gate_cmd = gate_cmd;
    sense_w.flag_in = flag_pin;
  end

  psfm_monitor #(.SC_RESET(20), .PWM_PER(64), .SLEW_FLT(4)) DUT (
    .clock(clock), .sys_rst(sys_rst), .sense(sense_w),
    .slew_res_code(slew_res_code), .temp_duty(temp_duty), .drive(drv),
    .slew_setting(slew_setting), .alarm_out_n(alarm_out_n),
    .overcurrent_flag_n(overcurrent_flag_n),
    .overcurrent_flag_oe_n(flag_oe_n), .thermal_pwm_out(pwm));

  psfm_ctrl_model ctrl (
    .clock(clock), .want_on(want_on), .combined(tie_flag),
    .alarm_out_n(alarm_out_n), .overcurrent_flag_n(overcurrent_flag_n),
    .gate_cmd(gate_cmd), .code(code));

  initial clock = 1'b0;
  always #10 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic power_up();
    sys_rst = 1'b1;
    sn.series_on = 1'b0;
    cyc(5);
    sys_rst = 1'b0;
    cyc(10);
    check("alarm_start", 8'h0, 8'(alarm_out_n));
    sn.series_on = 1'b1;
    for (int i = 0; i < 12 && alarm_out_n !== 1'b1; i++) cyc(1);
    if (alarm_out_n !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_overcurrent();
    want_on = 1'b1;
    cyc(8);
    check("gate_on", 8'h1, 8'(drv.gate_on));
    check("rails", 8'h3, 8'({drv.aux_en, drv.neg_en}));
    sn.oc_trip = 1'b1;
    cyc(3);
    check("gate_oc_delay", 8'h1, 8'(drv.gate_on));
    cyc(10);
    check("gate_oc", 8'h0, 8'(drv.gate_on));
    check("code_oc", 8'h2, 8'(code));
    sn.oc_trip = 1'b0;
    want_on = 1'b0;
    cyc(8);
    check("code_oc_clr", 8'h3, 8'(code));
    want_on = 1'b1;
    cyc(8);
    check("gate_next", 8'h1, 8'(drv.gate_on));
    sn.oc_trip = 1'b1;
    cyc(4);
    sn.sc_trip = 1'b1;
    cyc(10);
    check("code_late_sc", 8'h2, 8'(code));
    check("slow_late_sc", 8'h0, 8'(drv.slow_off));
    sn.oc_trip = 1'b0;
    sn.sc_trip = 1'b0;
    want_on = 1'b0;
    cyc(8);
  endtask

  task automatic t_short();
    want_on = 1'b1;
    cyc(8);
    sn.oc_trip = 1'b1;
    cyc(1);
    sn.sc_trip = 1'b1;
    cyc(6);
    check("gate_sc", 8'h0, 8'(drv.gate_on));
    check("slow_off", 8'h1, 8'(drv.slow_off));
    check("code_sc", 8'h0, 8'(code));
    sn.oc_trip = 1'b0;
    sn.sc_trip = 1'b0;
    want_on = 1'b0;
    cyc(10);
    want_on = 1'b1;
    cyc(8);
    check("gate_sc_held", 8'h0, 8'(drv.gate_on));
    check("code_sc_held", 8'h0, 8'(code));
    want_on = 1'b0;
    cyc(30);
    check("code_sc_clr", 8'h3, 8'(code));
    want_on = 1'b1;
    cyc(8);
    check("gate_sc_clr", 8'h1, 8'(drv.gate_on));
    want_on = 1'b0;
    cyc(4);
  endtask

  task automatic t_thermal();
    int hi;
    {sn.gan_rise, sn.gan_fall, sn.drain_neg} = 3'h7;
    cyc(10);
    check("code_ot", 8'h1, 8'(code));
    check("gate_3q", 8'h1, 8'(drv.gate_on));
    {sn.drain_neg, sn.drain_fwd} = 2'h1;
    cyc(6);
    check("gate_1q", 8'h0, 8'(drv.gate_on));
    hi = 0;
    repeat (70) begin
      cyc(1);
      hi += int'(pwm === 1'b1);
    end
    check("pwm_ot_hold", 8'd70, 8'(hi));
    {sn.drv_rise, sn.drv_fall, sn.drain_neg, sn.drain_fwd} = 4'he;
    cyc(6);
    check("drv_ot_off", 8'h0, 8'({drv.aux_en, drv.neg_en, drv.gate_on}));
    check("code_drv_ot", 8'h1, 8'(code));
    {sn.drv_rise, sn.drv_fall} = 2'h0;
    cyc(6);
    check("gate_idm_back", 8'h1, 8'(drv.gate_on));
    check("code_idm_back", 8'h1, 8'(code));
    {sn.gan_rise, sn.gan_fall, sn.drain_neg} = 3'h0;
    cyc(8);
    check("code_cool", 8'h3, 8'(code));
    check("rails_cool", 8'h3, 8'({drv.aux_en, drv.neg_en}));
  endtask

  task automatic t_supply_undervoltage_lock();
    want_on = 1'b1;
    cyc(8);
    sn.supply_ok = 1'b0;
    cyc(6);
    check("gate_uv", 8'h0, 8'(drv.gate_on));
    check("code_uv", 8'h1, 8'(code));
    sn.supply_ok = 1'b1;
    cyc(10);
    check("code_uv_clr", 8'h3, 8'(code));
    want_on = 1'b0;
    cyc(4);
  endtask

  task automatic t_slew();
    sn.slew_gnd = 1'b0;
    slew_res_code = 4'h5;
    cyc(30);
    check("slew_res", 8'h5, 8'(slew_setting));
    sn.slew_open = 1'b1;
    cyc(6);
    check("code_open", 8'h1, 8'(code));
    sn.slew_open = 1'b0;
    cyc(6);
  endtask

  task automatic t_pwm();
    logic [7:0] duties [3] = '{8'h00, 8'h80, 8'hff};
    int hi;
    int rises;
    int wid;
    int run;
    int min_run;
    logic last;
    min_run = 255;
    foreach (duties[k]) begin
      temp_duty = duties[k];
      wid = (int'(duties[k]) * 64) >> 8;
      if (wid < 2) wid = 2;
      cyc(192);
      hi = 0;
      rises = 0;
      last = pwm;
      run = 0;
      repeat (128) begin
        cyc(1);
        hi += int'(pwm === 1'b1);
        rises += int'(pwm === 1'b1 && last === 1'b0);
        // Only pulses that start inside the window are measured
        if (pwm === 1'b1 && last === 1'b0) begin
          run = 1;
        end else if (pwm === 1'b1 && run > 0) begin
          run++;
        end else if (pwm !== 1'b1) begin
          if (run > 0 && run < min_run) begin
            min_run = run;
          end
          run = 0;
        end
        last = pwm;
      end
      check("pwm_high", 8'(2 * wid), 8'(hi));
      check("pwm_periods", 8'h2, 8'(rises));
    end
    check("pwm_min", 8'(MIN_PULSE_CYC), 8'(min_run));
  endtask

  task automatic t_combined();
    tie_flag = 1'b1;
    {sn.slew_aux, sn.slew_gnd} = 2'h2;
    power_up();
    check("flag_oe_n", 8'h1, 8'(flag_oe_n));
    check("slew_aux", 8'ha, 8'(slew_setting));
    sn.slew_aux = 1'b0;
    slew_res_code = 4'h3;
    cyc(30);
    check("slew_frozen", 8'ha, 8'(slew_setting));
    want_on = 1'b1;
    cyc(8);
    sn.oc_trip = 1'b1;
    cyc(12);
    check("code_comb_oc", 8'h1, 8'(code));
    check("gate_comb_oc", 8'h0, 8'(drv.gate_on));
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    sn = '0;
    sn.supply_ok = 1'b1;
    sn.slew_gnd = 1'b1;
    slew_res_code = 4'h0;
    temp_duty = 8'h00;
    want_on = 1'b0;
    tie_flag = 1'b0;
    power_up();
    check("slew_gnd", 8'hf, 8'(slew_setting));
    check("flag_driven", 8'h0, 8'(flag_oe_n));
    t_overcurrent();
    t_short();
    t_pwm();
    t_thermal();
    t_supply_undervoltage_lock();
    t_slew();
    t_combined();
    tally_and_finish();
  end
endmodule // tb

// ---- verilog/psfm_monitor.sv ----
// Fault state, reporting, slew select and thermal PWM of the switch
//
// Operation
// - Overcurrent: switch off after delay, flag low
// - Overcurrent clears when gate command falls
// - Delayed overcurrent versus short trip classifies fault
// - Short circuit uses slowed turn-off strength
// - Short latches off until long low command
// - Switch overheat enters diode emulation
// - Driver overheat disables rails and transistor
// - Alarm low while hot, auto clear
// - Driver cools, switch hot: resume emulation
// - Undervoltage holds transistor off, alarm low
// - Two-pin status code, alarm push-pull, flag released in start-up and combined mode
// - Alarm low until series transistor on
// - Flag tied low at power-up: alarm only
// - Protection independent of status outputs
// - Slew rate chosen from slew pin
// - Aux short checked once, then ignored
// - Otherwise slew pin filtered and tracked
// - Thermal PWM at nine kilohertz period
// - Duty rises linearly with temperature
// - High pulse never narrower than minimum
// - Switch overtemperature holds thermal PWM high
module psfm_monitor
  import psfm_pkg::*;
#(
  parameter int SC_RESET = SC_RESET_CYC,
  parameter int PWM_PER  = PWM_PERIOD_CYC,
  parameter int SLEW_FLT = SLEW_FILT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Comparators and pins
  input  wire psfm_sense_t sense,
  input  wire logic [3:0]  slew_res_code,
  input  wire logic [7:0]  temp_duty,
  // Drive
  output psfm_drive_t      drive,
  output logic [3:0]       slew_setting,
  // Status pins
  output logic             alarm_out_n,
  output logic             overcurrent_flag_n,
  output logic             overcurrent_flag_oe_n,
  output logic             thermal_pwm_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SC_RESET < 1 || SC_RESET > 65535) begin : g_chk_sc
    $error("SC_RESET out of range");
  end
  if (PWM_PER < 4 * MIN_PULSE_CYC || PWM_PER > 8191) begin : g_chk_pwm
    $error("PWM_PER out of range");
  end
  if (SLEW_FLT < 2 || SLEW_FLT > 65535) begin : g_chk_flt
    $error("SLEW_FLT out of range");
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  psfm_sense_t s;
  logic [3:0]  slew_res_s;
  logic [7:0]  temp_duty_s;

  psfm_sync #(.W($bits(psfm_sense_t) + 12)) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({sense, slew_res_code, temp_duty}),
    .sync_out ({s, slew_res_s, temp_duty_s})
  );

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  psfm_state_t state_q, state_d;
  logic        gate_prev_q;
  logic        gan_ot_q, drv_ot_q;
  logic        oc_flag_q, sc_hit_q, oc_off_q;
  logic [3:0]  oc_cnt_q;
  logic [15:0] low_cnt_q;
  logic        idm_on_q;
  logic        combined_q, aux_lock_q;

  wire gate_fall  = gate_prev_q & ~s.gate_cmd;
  wire sc_release = (low_cnt_q >= 16'(SC_RESET));
  wire start_done = s.series_on & s.supply_ok;
  wire st_short   = (state_q == ST_SHORT);
  wire st_idm     = (state_q == ST_IDM);

  // ----------------------------------------------------------------
  // Current fault classification
  // ----------------------------------------------------------------
  wire oc_active  = s.oc_trip & s.gate_cmd & (state_q == ST_RUN);
  wire oc_counted = oc_active | (oc_cnt_q != 4'h0);
  wire win_done   = (oc_cnt_q >= 4'(OC_WINDOW_CYC));
  wire off_done   = (oc_cnt_q >= 4'(OC_OFF_CYC));
  wire sc_first   = s.sc_trip & oc_counted & ~win_done & ~oc_flag_q;
  wire oc_set     = oc_counted & win_done & ~sc_hit_q;

  always_ff @(posedge clock) begin
    if (sys_rst || !s.gate_cmd) begin
      oc_cnt_q  <= 4'h0;
      oc_flag_q <= 1'b0;
      oc_off_q  <= 1'b0;
    end else begin
      if (oc_counted && oc_cnt_q != 4'hf) begin
        oc_cnt_q <= oc_cnt_q + 4'h1;
      end
      if (oc_set) begin
        oc_flag_q <= 1'b1;
      end
      if (oc_counted && off_done) begin
        oc_off_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sc_hit_q <= 1'b0;
    end else begin
      sc_hit_q <= sc_first | (st_short & ~sc_release);
    end
  end

  // ----------------------------------------------------------------
  // Short latch release counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || s.gate_cmd || !st_short) begin
      low_cnt_q <= 16'h0;
    end else if (!sc_release) begin
      low_cnt_q <= low_cnt_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Thermal latches with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gan_ot_q    <= 1'b0;
      drv_ot_q    <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      gan_ot_q    <= s.gan_rise | (gan_ot_q & s.gan_fall);
      drv_ot_q    <= s.drv_rise | (drv_ot_q & s.drv_fall);
      gate_prev_q <= s.gate_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_START: begin
        if (start_done) begin
          state_d = ST_RUN;
        end
      end
      ST_SUPPLY_UNDERVOLTAGE_LOCK: begin
        if (s.supply_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_SHORT: begin
        if (sc_release) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN, ST_IDM, ST_DRVOT: begin
        if (sc_first) begin
          state_d = ST_SHORT;
        end else if (drv_ot_q) begin
          state_d = ST_DRVOT;
        end else if (gan_ot_q) begin
          state_d = ST_IDM;
        end else begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_START;
      end
    endcase
    if (!s.supply_ok && state_q != ST_START) begin
      state_d = ST_SUPPLY_UNDERVOLTAGE_LOCK;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_START;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Diode emulation: on for reverse flow, off for forward flow
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || !st_idm || gate_fall || s.drain_fwd) begin
      idm_on_q <= 1'b0;
    end else if (s.drain_neg) begin
      idm_on_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power-up straps
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      combined_q <= 1'b0;
      aux_lock_q <= 1'b0;
    end else if (state_q == ST_START && start_done) begin
      combined_q <= ~s.flag_in;
      aux_lock_q <= s.slew_aux;
    end
  end

  // ----------------------------------------------------------------
  // Drive outputs, independent of status pins
  // ----------------------------------------------------------------
  wire run_on = (state_q == ST_RUN) & s.gate_cmd & ~oc_off_q;
  wire rails  = (state_q != ST_DRVOT) & (state_q != ST_SUPPLY_UNDERVOLTAGE_LOCK);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drive <= '0;
    end else begin
      drive.gate_on  <= (run_on | (st_idm & idm_on_q)) & ~sc_first
                        & ~oc_off_q;
      drive.slow_off <= st_short | sc_first;
      drive.aux_en   <= rails;
      drive.neg_en   <= rails;
    end
  end

  // ----------------------------------------------------------------
  // Status code
  // ----------------------------------------------------------------
  wire alarm_cond = (state_q != ST_RUN) | s.slew_open
                  | (combined_q & oc_flag_q);
  wire flag_cond  = ~combined_q & (st_short | oc_flag_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      alarm_out_n           <= 1'b0;
      overcurrent_flag_n    <= 1'b1;
      overcurrent_flag_oe_n <= 1'b1;
    end else begin
      alarm_out_n           <= ~alarm_cond;
      overcurrent_flag_n    <= ~flag_cond;
      overcurrent_flag_oe_n <= (state_q == ST_START) | combined_q;
    end
  end

  // ----------------------------------------------------------------
  // Slew select with stability filter
  // ----------------------------------------------------------------
  logic [3:0]  slew_cand_q;
  logic [15:0] slew_cnt_q;
  wire  [3:0]  slew_raw  = s.slew_gnd ? SLEW_GND : slew_res_s;
  wire         slew_same = (slew_raw == slew_cand_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slew_cand_q  <= SLEW_RESET;
      slew_cnt_q   <= 16'h0;
      slew_setting <= SLEW_RESET;
    end else if (aux_lock_q) begin
      slew_setting <= SLEW_AUX;
    end else begin
      slew_cand_q <= slew_raw;
      if (!slew_same) begin
        slew_cnt_q <= 16'h0;
      end else if (slew_cnt_q < 16'(SLEW_FLT)) begin
        slew_cnt_q <= slew_cnt_q + 16'h1;
      end else begin
        slew_setting <= slew_cand_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thermal PWM
  // ----------------------------------------------------------------
  logic [12:0] pwm_cnt_q;
  logic [12:0] high_q;
  wire  [20:0] prod    = 21'(temp_duty_s) * 21'(PWM_PER);
  wire  [12:0] high_rw = prod[20:8];
  wire  [12:0] high_mn = (high_rw < 13'(MIN_PULSE_CYC))
                       ? 13'(MIN_PULSE_CYC) : high_rw;
  wire         wrap    = (pwm_cnt_q == 13'(PWM_PER - 1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwm_cnt_q       <= 13'h0;
      high_q          <= 13'(MIN_PULSE_CYC);
      thermal_pwm_out <= 1'b0;
    end else begin
      pwm_cnt_q <= wrap ? 13'h0 : pwm_cnt_q + 13'h1;
      if (wrap) begin
        high_q <= high_mn;
      end
      thermal_pwm_out <= gan_ot_q | (pwm_cnt_q < high_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_oc_gate_off: assert property (
    oc_off_q |=> !drive.gate_on)
    else $error("gate on during overcurrent");

  a_oc_clears: assert property (
    oc_flag_q && !s.gate_cmd |=> !oc_flag_q)
    else $error("overcurrent flag not cleared");

  a_short_class: assert property (
    sc_first |=> state_q == ST_SHORT ##1 drive.slow_off && !drive.gate_on)
    else $error("short not latched");

  a_short_slow: assert property (
    st_short |=> drive.slow_off)
    else $error("slow turn-off missing");

  a_short_hold: assert property (
    st_short && !sc_release && s.gate_cmd && s.supply_ok |=> st_short)
    else $error("short latch released early");

  a_drvot_rails: assert property (
    state_q == ST_DRVOT |=> !drive.aux_en && !drive.neg_en
                            && !drive.gate_on)
    else $error("rails on in driver overheat");

  a_supply_undervoltage_lock_off: assert property (
    state_q == ST_SUPPLY_UNDERVOLTAGE_LOCK |=> !drive.gate_on && !alarm_out_n)
    else $error("switching under low supply");

  a_start_alarm: assert property (
    state_q == ST_START |=> !alarm_out_n)
    else $error("alarm released during start-up");

  a_short_code: assert property (
    st_short && !combined_q |=> !alarm_out_n && !overcurrent_flag_n)
    else $error("short code wrong");

  a_aux_lock: assert property (
    aux_lock_q |=> slew_setting == SLEW_AUX)
    else $error("slew pin tracked after aux short");

  a_pwm_min: assert property (
    $rose(thermal_pwm_out) |=> thermal_pwm_out)
    else $error("thermal pulse too narrow");

  a_pwm_ot_high: assert property (
    gan_ot_q |=> thermal_pwm_out)
    else $error("thermal output not held high");

endmodule // psfm_monitor

// ---- verilog/psfm_sync.sv ----
// Two-stage synchroniser for a vector of independent levels
module psfm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // psfm_sync
